/* File: rtl/serial_port_pkg.sv */
// shared constants, rate table and hex helpers for the ascii sentence serial port
package serial_port_pkg;
  // ***************************************************************
  // clock, framing and timing
  // ***************************************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_PERIOD_NS = 1_000_000;
  localparam int MS_CYCLES_DEFAULT = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SAMPLE_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] SAMPLE_MID = 4'(OVERSAMPLE / 2 - 1);
  localparam int DATA_BITS = 8;
  localparam int FRAME_BITS = 10;
  localparam logic [3:0] FRAME_COUNT = 4'(FRAME_BITS);
  localparam logic [2:0] DATA_LAST = 3'(DATA_BITS - 1);
  localparam logic LINE_IDLE = 1'b1;
  localparam logic START_LEVEL = 1'b0;
  localparam logic STOP_LEVEL = 1'b1;
  localparam logic ASCII_MSB = 1'b0;

  // ***************************************************************
  // line rates
  // ***************************************************************
  typedef enum logic [2:0] {
    RATE_1200, RATE_2400, RATE_4800, RATE_9600, RATE_19200, RATE_38400
  } rate_type;
  localparam rate_type DEFAULT_RATE = RATE_19200;

  // clock cycles per oversample tick for each rate
  function automatic logic [15:0] rate_divisor(input rate_type r, input int clkHz = CLK_HZ);
    int bps;
    case (r)
      RATE_1200: bps = 1200;
      RATE_2400: bps = 2400;
      RATE_4800: bps = 4800;
      RATE_9600: bps = 9600;
      RATE_38400: bps = 38400;
      default: bps = 19200;
    endcase
    return 16'(clkHz / (bps * OVERSAMPLE));
  endfunction

  // ***************************************************************
  // sentence characters
  // ***************************************************************
  localparam logic [7:0] CHAR_DOLLAR = 8'h24;
  localparam logic [7:0] CHAR_STAR = 8'h2A;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_NINE = 8'h39;
  localparam logic [7:0] ASCII_UPPER_A = 8'h41;
  localparam logic [7:0] ASCII_UPPER_F = 8'h46;
  localparam logic [7:0] HEX_LETTER_BASE = 8'h37;
  localparam logic [3:0] HEX_TEN = 4'hA;
  localparam logic [3:0] HEX_LETTER_ADJ = 4'h9;

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    if (n < HEX_TEN) return 8'(ASCII_ZERO + {4'h0, n});
    return 8'(HEX_LETTER_BASE + {4'h0, n});
  endfunction

  // {valid, nibble}; only upper-case digits are accepted
  function automatic logic [4:0] hex_value(input logic [7:0] c);
    if (c >= ASCII_ZERO && c <= ASCII_NINE) return {1'b1, c[3:0]};
    if (c >= ASCII_UPPER_A && c <= ASCII_UPPER_F) return {1'b1, 4'(c[3:0] + HEX_LETTER_ADJ)};
    return 5'h00;
  endfunction
endpackage

/* File: rtl/serial_char_tx.sv */
// one-character serial transmitter, 16x tick timed
`timescale 1ns/1ps
module serial_char_tx (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEnable,
  input wire logic sampleTick,
  input wire logic [7:0] charData,
  input wire logic charValid,
  output logic charReady,
  output logic lineOut,
  output logic busy
);
  import serial_port_pkg::*;

  logic [9:0] shifter;
  logic [3:0] tickCount;
  logic [3:0] bitCount;

  assign charReady = !busy;
  assign lineOut = shifter[0];

  // load a whole frame, then shift one bit every sixteen ticks
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      shifter <= '1;
      tickCount <= '0;
      bitCount <= '0;
      busy <= 1'b0;
    end else if (clkEnable) begin
      if (!busy && charValid) begin
        shifter <= {STOP_LEVEL, ASCII_MSB, charData[6:0], START_LEVEL};
        tickCount <= '0;
        bitCount <= FRAME_COUNT;
        busy <= 1'b1;
      end else if (busy && sampleTick) begin
        if (tickCount == SAMPLE_LAST) begin
          tickCount <= '0;
          shifter <= {LINE_IDLE, shifter[9:1]};
          bitCount <= bitCount - 4'h1;
          if (bitCount == 4'h1) busy <= 1'b0;
        end else begin
          tickCount <= tickCount + 4'h1;
        end
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_frame_shape: assert property ($rose(busy) |-> !lineOut && shifter[9] && !shifter[8])
    else $error("frame loaded without start, stop or zero msb");
  a_idle_high: assert property (!busy |-> lineOut)
    else $error("line not idle high between characters");
  a_bit_range: assert property (busy |-> bitCount != 4'h0 && bitCount <= FRAME_COUNT)
    else $error("bit count out of frame");
endmodule // serial_char_tx

/* File: rtl/serial_char_rx.sv */
// one-character serial receiver with centre sampling
`timescale 1ns/1ps
module serial_char_rx (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEnable,
  input wire logic sampleTick,
  input wire logic lineIn,
  input wire logic listen,
  output logic [7:0] charData,
  output logic charStrobe,
  output logic frameError,
  output logic busy
);
  import serial_port_pkg::*;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;
  rx_state_type state;
  logic [3:0] tickCount;
  logic [2:0] bitIndex;
  logic [7:0] shifter;
  logic prevLine;

  assign busy = state != RX_IDLE;

  // start edge, half-bit check, then one sample per bit centre
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= RX_IDLE;
      tickCount <= '0;
      bitIndex <= '0;
      shifter <= '0;
      charData <= '0;
      charStrobe <= 1'b0;
      frameError <= 1'b0;
      prevLine <= 1'b1;
    end else if (clkEnable) begin
      charStrobe <= 1'b0;
      frameError <= 1'b0;
      prevLine <= lineIn;
      case (state)
        RX_IDLE: begin
          if (listen && prevLine && !lineIn) begin
            state <= RX_START;
            tickCount <= '0;
          end
        end
        RX_START: begin
          if (sampleTick) begin
            tickCount <= tickCount + 4'h1;
            if (tickCount == SAMPLE_MID) begin
              // a glitch shorter than half a bit is dropped here
              state <= lineIn ? RX_IDLE : RX_DATA;
              tickCount <= '0;
              bitIndex <= '0;
            end
          end
        end
        RX_DATA: begin
          if (sampleTick) begin
            tickCount <= tickCount + 4'h1;
            if (tickCount == SAMPLE_LAST) begin
              shifter <= {lineIn, shifter[7:1]};
              bitIndex <= bitIndex + 3'h1;
              if (bitIndex == DATA_LAST) state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (sampleTick) begin
            tickCount <= tickCount + 4'h1;
            if (tickCount == SAMPLE_LAST) begin
              state <= RX_IDLE;
              if (lineIn == STOP_LEVEL) begin
                charData <= shifter;
                charStrobe <= 1'b1;
              end else begin
                frameError <= 1'b1;
              end
            end
          end
        end
        default: state <= RX_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_stop_high: assert property (charStrobe |-> $past(lineIn))
    else $error("character kept with low stop bit");
  a_error_low: assert property (frameError |-> !$past(lineIn) && !charStrobe)
    else $error("frame error without low stop bit");
endmodule // serial_char_rx

/* File: rtl/ascii_sentence_serial_port.sv */
// ascii sentence serial port: rate, framing, checksum, arbitration, duplex
`timescale 1ns/1ps
// Function
// - characters carry one start bit then eight data bits, lsb first
// - no parity; the top data bit of every character is zero
// - one stop bit closes each character; ten bit periods in all
// - line rate comes up at 19200 bits per second
// - rate selectable among 1200, 2400, 4800, 9600, 19200, 38400
// - continuous mode pulses outputDue at the stored repetition rate and sends unsolicited sentences whenever offered
// - every input sentence from the host with a good checksum sets replyOwed until a reply finishes
// - a reply may wait until an unsolicited sentence in flight finishes
// - every sentence ends its data with a two-character checksum
// - checksum is the standard xor of characters between dollar and star
// - full duplex lets transmit and receive run at once
// - half duplex: only one side drives the shared line at a time
module ascii_sentence_serial_port #(
  parameter int MS_CYCLES = serial_port_pkg::MS_CYCLES_DEFAULT,
  parameter int REP_W = 16,
  parameter int CLK_FREQ = serial_port_pkg::CLK_HZ
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEnable,
  input wire serial_port_pkg::rate_type rateSel,
  input wire logic rateLoad,
  input wire logic halfDuplex,
  input wire logic continuousMode,
  input wire logic [REP_W-1:0] repeatPeriodMs,
  output logic outputDue,
  input wire logic serialInLine,
  output logic serial_out_line,
  output logic lineDriveEn_n,
  input wire logic [7:0] unsolData,
  input wire logic unsolValid,
  input wire logic unsolLast,
  output logic unsolReady,
  input wire logic [7:0] replyData,
  input wire logic replyValid,
  input wire logic replyLast,
  output logic replyReady,
  output logic [7:0] rxData,
  output logic rxValid,
  output logic rxSentenceEnd,
  output logic rxChecksumOk,
  output logic replyOwed,
  output logic cmdOverrun,
  output logic txBusy
);
  import serial_port_pkg::*;

  localparam int MS_W = $clog2(MS_CYCLES + 1);

  // ***************************************************************
  // line rate and oversample tick
  // ***************************************************************
  rate_type rate;
  logic [15:0] divCount;
  logic [15:0] divisor;
  logic sampleTick;

  assign divisor = rate_divisor(rate, CLK_FREQ);

  // rate holds until software-side logic loads a new one
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rate <= DEFAULT_RATE;
    end else if (clkEnable && rateLoad) begin
      rate <= rateSel;
    end
  end

  // restart the divider on a rate change so the first tick is full length
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      divCount <= '0;
    end else if (clkEnable) begin
      if (rateLoad || sampleTick) divCount <= '0;
      else divCount <= divCount + 16'h1;
    end
  end
  assign sampleTick = divCount == divisor - 16'h1;

  // ***************************************************************
  // pin synchroniser and character engines
  // ***************************************************************
  logic serialInSync1;
  logic serialInSync2;
  logic [7:0] rxChar;
  logic rxStrobe;
  logic rxFrameErr;
  logic rxBusy;
  logic listen;
  logic [7:0] charData;
  logic charValid;
  logic charReady;
  logic charAccept;
  logic driving;

  // two flops before anything looks at the line
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      serialInSync1 <= LINE_IDLE;
      serialInSync2 <= LINE_IDLE;
    end else if (clkEnable) begin
      serialInSync1 <= serialInLine;
      serialInSync2 <= serialInSync1;
    end
  end

  // own echo on a shared pair must not be taken as input
  assign listen = !(halfDuplex && driving);

  serial_char_rx receiver (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clkEnable(clkEnable),
    .sampleTick(sampleTick),
    .lineIn(serialInSync2),
    .listen(listen),
    .charData(rxChar),
    .charStrobe(rxStrobe),
    .frameError(rxFrameErr),
    .busy(rxBusy)
  );

  serial_char_tx transmitter (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clkEnable(clkEnable),
    .sampleTick(sampleTick),
    .charData(charData),
    .charValid(charValid),
    .charReady(charReady),
    .lineOut(serial_out_line),
    .busy(txBusy)
  );

  // ***************************************************************
  // outgoing sentence framer
  // ***************************************************************
  typedef enum logic [2:0] {
    TX_IDLE, TX_DOLLAR, TX_BODY, TX_STAR, TX_HI, TX_LO, TX_CR, TX_LF
  } tx_state_type;
  tx_state_type txState;
  logic srcReply;
  logic [7:0] txSum;
  logic [7:0] selData;
  logic selValid;
  logic selLast;
  logic startOk;
  logic replyDone;

  assign selData = srcReply ? replyData : unsolData;
  assign selValid = srcReply ? replyValid : unsolValid;
  assign selLast = srcReply ? replyLast : unsolLast;
  assign charAccept = charValid && charReady;
  assign unsolReady = txState == TX_BODY && !srcReply && charReady;
  assign replyReady = txState == TX_BODY && srcReply && charReady;
  assign driving = txState != TX_IDLE || txBusy;
  // on a shared pair never start over a character coming in
  assign startOk = !(halfDuplex && rxBusy);
  assign replyDone = charAccept && txState == TX_LF && srcReply;

  // character offered to the transmitter in each framing step
  always_comb begin
    charValid = 1'b0;
    charData = CHAR_DOLLAR;
    case (txState)
      TX_IDLE: charValid = 1'b0;
      TX_DOLLAR: charValid = 1'b1;
      TX_BODY: begin
        charValid = selValid;
        charData = selData;
      end
      TX_STAR: begin
        charValid = 1'b1;
        charData = CHAR_STAR;
      end
      TX_HI: begin
        charValid = 1'b1;
        charData = hex_char(txSum[7:4]);
      end
      TX_LO: begin
        charValid = 1'b1;
        charData = hex_char(txSum[3:0]);
      end
      TX_CR: begin
        charValid = 1'b1;
        charData = CHAR_CR;
      end
      TX_LF: begin
        charValid = 1'b1;
        charData = CHAR_LF;
      end
      default: charValid = 1'b0;
    endcase
  end

  // unsolicited output wins the start; a pending reply waits it out
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      txState <= TX_IDLE;
      srcReply <= 1'b0;
    end else if (clkEnable) begin
      case (txState)
        TX_IDLE: begin
          if (startOk && continuousMode && unsolValid) begin
            srcReply <= 1'b0;
            txState <= TX_DOLLAR;
          end else if (startOk && replyValid) begin
            srcReply <= 1'b1;
            txState <= TX_DOLLAR;
          end
        end
        TX_DOLLAR: if (charAccept) txState <= TX_BODY;
        TX_BODY: if (charAccept && selLast) txState <= TX_STAR;
        TX_STAR: if (charAccept) txState <= TX_HI;
        TX_HI: if (charAccept) txState <= TX_LO;
        TX_LO: if (charAccept) txState <= TX_CR;
        TX_CR: if (charAccept) txState <= TX_LF;
        TX_LF: if (charAccept) txState <= TX_IDLE;
        default: txState <= TX_IDLE;
      endcase
    end
  end

  // running xor of the body characters as they go out, top bit forced low
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      txSum <= '0;
    end else if (clkEnable && charAccept) begin
      if (txState == TX_DOLLAR) txSum <= '0;
      else if (txState == TX_BODY) txSum <= txSum ^ {ASCII_MSB, selData[6:0]};
    end
  end

  // enable is low while we own the pair; full duplex drives always
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      lineDriveEn_n <= 1'b1;
    end else if (clkEnable) begin
      lineDriveEn_n <= halfDuplex ? !driving : 1'b0;
    end
  end

  // ***************************************************************
  // repetition timer for continuous mode
  // ***************************************************************
  logic [MS_W-1:0] msCount;
  logic [REP_W-1:0] repCount;
  logic msTick;

  assign msTick = msCount == MS_W'(MS_CYCLES - 1);

  // a zero period keeps the timer silent rather than firing every tick
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      msCount <= '0;
      repCount <= '0;
      outputDue <= 1'b0;
    end else if (clkEnable) begin
      outputDue <= 1'b0;
      msCount <= msTick ? '0 : msCount + MS_W'(1);
      if (!continuousMode) begin
        repCount <= '0;
      end else if (msTick) begin
        if (repCount >= repeatPeriodMs - REP_W'(1)) begin
          repCount <= '0;
          outputDue <= repeatPeriodMs != '0;
        end else begin
          repCount <= repCount + REP_W'(1);
        end
      end
    end
  end

  // ***************************************************************
  // incoming sentence parser
  // ***************************************************************
  typedef enum logic [1:0] {P_HUNT, P_BODY, P_HI, P_LO} parse_state_type;
  parse_state_type parseState;
  logic [7:0] rxSum;
  logic [3:0] hiNibble;
  logic [4:0] rxHex;
  logic plainChar;
  logic sentenceGood;

  assign rxHex = hex_value(rxChar);
  assign plainChar = rxStrobe && rxChar[7] == ASCII_MSB && rxChar != CHAR_DOLLAR;
  assign sentenceGood = plainChar && parseState == P_LO && rxHex[4]
    && {hiNibble, rxHex[3:0]} == rxSum;

  // a dollar always restarts; bad characters throw the sentence away
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      parseState <= P_HUNT;
      rxSum <= '0;
      hiNibble <= '0;
      rxData <= '0;
      rxValid <= 1'b0;
      rxSentenceEnd <= 1'b0;
      rxChecksumOk <= 1'b0;
    end else if (clkEnable) begin
      rxValid <= 1'b0;
      rxSentenceEnd <= 1'b0;
      if (rxFrameErr) begin
        parseState <= P_HUNT;
      end else if (rxStrobe && rxChar == CHAR_DOLLAR) begin
        parseState <= P_BODY;
        rxSum <= '0;
      end else if (rxStrobe && rxChar[7] != ASCII_MSB) begin
        parseState <= P_HUNT;
      end else if (plainChar) begin
        case (parseState)
          P_HUNT: parseState <= P_HUNT;
          P_BODY: begin
            if (rxChar == CHAR_STAR) begin
              parseState <= P_HI;
            end else begin
              rxSum <= rxSum ^ rxChar;
              rxData <= rxChar;
              rxValid <= 1'b1;
            end
          end
          P_HI: begin
            hiNibble <= rxHex[3:0];
            parseState <= rxHex[4] ? P_LO : P_HUNT;
          end
          P_LO: begin
            rxSentenceEnd <= 1'b1;
            rxChecksumOk <= sentenceGood;
            parseState <= P_HUNT;
          end
          default: parseState <= P_HUNT;
        endcase
      end
    end
  end

  // owed answer: a new good sentence wins over a reply finishing
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      replyOwed <= 1'b0;
      cmdOverrun <= 1'b0;
    end else if (clkEnable) begin
      cmdOverrun <= sentenceGood && replyOwed && !replyDone;
      if (sentenceGood) replyOwed <= 1'b1;
      else if (replyDone) replyOwed <= 1'b0;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_rate_default: assert property ($rose(reset_n) |-> rate == DEFAULT_RATE)
    else $error("rate not at default after reset");
  a_rate_load: assert property (clkEnable && rateLoad |=> rate == $past(rateSel))
    else $error("selected rate not taken");
  a_due_continuous: assert property (outputDue |-> $past(continuousMode))
    else $error("unsolicited output due outside continuous mode");
  a_reply_owed: assert property (clkEnable && sentenceGood |=> replyOwed)
    else $error("good input sentence left unanswered");
  a_defer_reply: assert property (txState == TX_IDLE && clkEnable && startOk && continuousMode
    && unsolValid ##1 txState == TX_DOLLAR |-> !srcReply)
    else $error("reply started over unsolicited output");
  a_sum_high: assert property (txState == TX_HI |-> charData == hex_char(txSum[7:4]))
    else $error("checksum high character wrong");
  a_sum_order: assert property (clkEnable && charAccept && txState == TX_STAR
    |=> txState == TX_HI ##0 charData == hex_char(txSum[7:4]))
    else $error("checksum does not follow star");
  a_half_quiet: assert property (halfDuplex && txBusy |-> !listen)
    else $error("receiver open while driving shared line");
  a_full_drive: assert property ($past(reset_n) && $past(clkEnable) && !halfDuplex
    && $past(!halfDuplex) |-> !lineDriveEn_n && listen)
    else $error("full duplex line not driven or not listening");
endmodule // ascii_sentence_serial_port

/* File: test/host_model.sv */
// host side serial model: frames characters out and samples them back in
`timescale 1ns/1ps
module host_model (
  input wire logic clk_sys,
  input wire logic lineIn,
  output logic lineOut
);
  int bitCycles = 2592;
  initial lineOut = 1'b1;
  // ***************************************************************
  // character transfer
  // ***************************************************************
  // start low, data lsb first, stop high; line rests high between characters
  task automatic send_char(input logic [7:0] c);
    logic [9:0] frame;
    frame = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys);
      lineOut <= frame[i];
      repeat (bitCycles - 1) @(posedge clk_sys);
    end
  endtask
  // centre sampling keeps the result clear of edge races
  task automatic recv_char(output logic [7:0] c, output logic stopOk, output logic tmo);
    int k;
    k = 0;
    c = 8'h00;
    while (lineIn !== 1'b0 && k < 400000) begin
      @(posedge clk_sys);
      k++;
    end
    tmo = (k >= 400000);
    repeat (bitCycles / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (bitCycles) @(posedge clk_sys);
      c[i] = lineIn;
    end
    repeat (bitCycles) @(posedge clk_sys);
    stopOk = (lineIn === 1'b1);
  endtask
endmodule // host_model

/* File: test/tb_ascii_sentence_serial_port.sv */
// self-checking bench for the ascii sentence serial port
`timescale 1ns/1ps
module tb_ascii_sentence_serial_port;
  import serial_port_pkg::*;
  logic clk_sys, reset_n, rateLoad, continuousMode, replyValid, replyLast, stopOk, tmo;
  rate_type rateSel;
  logic [15:0] repeatPeriodMs;
  logic [7:0] replyData, rxData, seen, body, sum;
  logic outputDue, serialInLine, serial_out_line, unsolReady, replyReady, rxValid;
  logic rxSentenceEnd, rxChecksumOk, replyOwed, lineDriveEn_n, cmdOverrun, txBusy;
  logic clkEnable = 1'b1, halfDuplex = 1'b0, unsolValid = 1'b0;
  // line timing scaled to a slower clock so whole sentences fit a short run
  localparam int SIM_HZ = 10_000_000;
  logic [31:0] lfsr = 32'h69F7;
  int fails = 0, tests_run = 0, n;
  logic [7:0] msg [5];
  logic [7:0] expChars [7];

  ascii_sentence_serial_port #(.MS_CYCLES(20), .REP_W(16), .CLK_FREQ(SIM_HZ))
      ascii_sentence_serial_port_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .clkEnable(clkEnable), .rateSel(rateSel),
    .rateLoad(rateLoad), .halfDuplex(halfDuplex), .continuousMode(continuousMode),
    .repeatPeriodMs(repeatPeriodMs), .outputDue(outputDue), .serialInLine(serialInLine),
    .serial_out_line(serial_out_line), .lineDriveEn_n(lineDriveEn_n), .unsolData(8'h00),
    .unsolValid(unsolValid), .unsolLast(1'b1), .unsolReady(unsolReady),
    .replyData(replyData), .replyValid(replyValid), .replyLast(replyLast),
    .replyReady(replyReady), .rxData(rxData), .rxValid(rxValid),
    .rxSentenceEnd(rxSentenceEnd), .rxChecksumOk(rxChecksumOk), .replyOwed(replyOwed),
    .cmdOverrun(cmdOverrun), .txBusy(txBusy)
  );
  host_model host_model_inst (.clk_sys(clk_sys), .lineIn(serial_out_line), .lineOut(serialInLine));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] hex_of(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction
  function automatic int bit_cycles(input int bps);
    return (SIM_HZ / (bps * 16)) * 16;
  endfunction
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  function automatic logic pick(input int which);
    case (which)
      0: return outputDue;
      1: return rxValid;
      2: return rxSentenceEnd;
      3: return replyReady;
      default: return ~serial_out_line;
    endcase
  endfunction
  // sampled on the falling edge so registered outputs have settled
  task automatic wait_high(input int which, input int limit);
    int k;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (pick(which) !== 1'b1 && k < limit);
    if (k >= limit) begin
      fails++;
      $display("MISMATCH wait %0d expected 1 seen timeout", which);
      end_of_test();
    end
  endtask
  task automatic reset_dut();
    @(posedge clk_sys);
    reset_n <= 1'b0;
    replyValid <= 1'b0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    reset_n = 1'b0;
    rateLoad = 1'b0;
    rateSel = RATE_1200;
    continuousMode = 1'b0;
    repeatPeriodMs = 16'h0000;
    replyValid = 1'b0;
    replyLast = 1'b1;
    replyData = 8'h00;
    reset_dut();
    @(negedge clk_sys);
    check("idle line", serial_out_line, 16'h0001);
    // '$' is low for start, d0 and d1, then high for exactly one bit (d2)
    @(posedge clk_sys);
    replyData <= 8'h41;
    replyValid <= 1'b1;
    wait_high(4, 200);
    check("tx busy", txBusy, 16'h0001);
    check("drive en", lineDriveEn_n, 16'h0000);
    n = 0;
    while (serial_out_line === 1'b0 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    n = 0;
    while (serial_out_line === 1'b1 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    check("bit width", 16'(n), 16'(bit_cycles(19200)));
    // second reset aborts the sentence, then the repetition timer
    reset_dut();
    continuousMode <= 1'b1;
    repeatPeriodMs <= 16'h0002;
    wait_high(0, 200);
    // ten frozen cycles must push the next pulse out by exactly ten
    @(posedge clk_sys);
    clkEnable <= 1'b0;
    repeat (10) @(posedge clk_sys);
    clkEnable <= 1'b1;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (outputDue !== 1'b1 && n < 200);
    check("due spacing", 16'(n), 16'h0028);
    @(posedge clk_sys);
    continuousMode <= 1'b0;
    rateSel <= RATE_38400;
    rateLoad <= 1'b1;
    @(posedge clk_sys);
    rateLoad <= 1'b0;
    host_model_inst.bitCycles = bit_cycles(38400);
    lfsr = lfsr_next(lfsr);
    body = 8'h41 + 8'(lfsr[7:0] % 26);
    msg = '{8'h24, body, 8'h2A, hex_of(body[7:4]), hex_of(body[3:0])};
    fork
      foreach (msg[i]) host_model_inst.send_char(msg[i]);
      begin
        wait_high(1, 400000);
        check("rx char", rxData, body);
        wait_high(2, 400000);
        check("rx sum", rxChecksumOk, 16'h0001);
        check("owed", replyOwed, 16'h0001);
      end
    join
    // reply with the top bit set: only seven bits may reach the line
    lfsr = lfsr_next(lfsr);
    body = 8'hC1 + 8'(lfsr[7:0] % 26);
    sum = body & 8'h7F;
    expChars = '{8'h24, sum, 8'h2A, hex_of(sum[7:4]), hex_of(sum[3:0]), 8'h0D, 8'h0A};
    @(posedge clk_sys);
    replyData <= body;
    replyValid <= 1'b1;
    fork
      begin
        wait_high(3, 400000);
        check("unsol ready", unsolReady, 16'h0000);
        @(posedge clk_sys);
        replyValid <= 1'b0;
      end
      foreach (expChars[i]) begin
        host_model_inst.recv_char(seen, stopOk, tmo);
        check("tx char", seen, expChars[i]);
        check("tx stop", {stopOk, tmo}, 16'h0002);
      end
    join
    @(negedge clk_sys);
    check("owed cleared", replyOwed, 16'h0000);
    check("overrun", cmdOverrun, 16'h0000);
    end_of_test();
  end
  // hang guard
  initial begin
    repeat (100_000) @(posedge clk_sys);
    fails++;
    $display("MISMATCH run length expected finish seen timeout");
    end_of_test();
  end
endmodule // tb_ascii_sentence_serial_port
